/* rx_port_pkg.sv */
// Constants and types shared by the receive sample output port
`default_nettype none
package rx_port_pkg;
    localparam int DATA_W = 12;
    localparam int IDX_W = 8;
    localparam int WB_DW = 32;
    localparam int REG8_N = 6;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] DBL_SEL_IDX = 8'h39;
    localparam logic [IDX_W-1:0] DBL_OP_A_IDX = 8'h3A;
    localparam logic [IDX_W-1:0] DBL_OP_B_IDX = 8'h3B;
    localparam logic [IDX_W-1:0] DBL_OP_C_IDX = 8'h3C;
    localparam logic [IDX_W-1:0] DBL_PW_IDX = 8'h3E;
    localparam logic [IDX_W-1:0] DRIVE_IDX = 8'h63;
    localparam logic [IDX_W-1:0] PORT_CTRL_IDX = 8'h40;
    localparam logic [IDX_W-1:0] PORT_STAT_IDX = 8'h41;

    // Decode slots of the registers; slots 0 to 5 hold the byte-wide registers
    localparam logic [3:0] SLOT_DBL_SEL = 4'h0;
    localparam logic [3:0] SLOT_OP_A = 4'h1;
    localparam logic [3:0] SLOT_OP_B = 4'h2;
    localparam logic [3:0] SLOT_OP_C = 4'h3;
    localparam logic [3:0] SLOT_PW = 4'h4;
    localparam logic [3:0] SLOT_DRIVE = 4'h5;
    localparam logic [3:0] SLOT_CTRL = 4'h6;
    localparam logic [3:0] SLOT_STAT = 4'h7;
    localparam logic [3:0] SLOT_NONE = 4'hF;

    localparam logic [7:0] REG8_RST = 8'h00;
    localparam int RX_DBL_SEL_BIT = 1;
    localparam int RX_PW_LSB = 0;
    localparam int RX_PW_W = 3;
    localparam int STAT_PENDING_BIT = 0;
    localparam int STAT_DBL_BIT = 1;
    localparam int STAT_TX_BIT = 2;

    // Word rate limit and link cycles spent on each word slot
    localparam int MAX_WORD_RATE_MSPS = 200;
    localparam int LINK_CYCLES_PER_WORD = 2;

    typedef struct packed {
        logic decim_en;
        logic single_q_adc;
        logic single_adc_en;
        logic ddr_mode;
        logic receive_format_sel;
        logic flag_polarity_sel;
        logic pair_order_sel;
        logic out_clock_invert;
        logic half_duplex;
        logic port_en;
    } port_cfg_t;

    localparam int CTRL_W = 10;
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h001;
endpackage
`default_nettype wire

/* pair_link_if.sv */
// Carrier of sample pairs and configuration into the link clock domain
`default_nettype none
interface pair_link_if;
    import rx_port_pkg::*;
    logic [DATA_W-1:0] word_i;
    logic [DATA_W-1:0] word_q;
    logic req_tgl;
    logic ack_tgl;
    port_cfg_t cfg;
    modport src (output word_i, output word_q, output req_tgl, output cfg, input ack_tgl);
    modport dst (input word_i, input word_q, input req_tgl, input cfg, output ack_tgl);
endinterface
`default_nettype wire

/* link_serializer.sv */
// Link-side word serializer driving the shared port pins
`default_nettype none
module link_serializer
    import rx_port_pkg::*;
(
    input wire logic link_clk_i,
    input wire logic rst_i,
    pair_link_if.dst lnk,
    output logic [DATA_W-1:0] bus_o,
    output logic port_clk_o,
    output logic flag_o
);
    logic r1_q, r2_q, q1_q, q2_q, ph_q, second_q, clk_q, flag_q, ack_q;
    port_cfg_t c1_q, cfg_q;
    logic [DATA_W-1:0] data_q, hold_q;
    logic slot_end, fresh, i_sel;

    always_ff @(posedge link_clk_i) begin
        r1_q <= rst_i;
        r2_q <= r1_q;
        q1_q <= lnk.req_tgl;
        q2_q <= q1_q;
        c1_q <= lnk.cfg;
        cfg_q <= c1_q;
    end

    assign slot_end = ph_q;
    assign fresh = (q2_q != ack_q);
    // Single mode always shows the active ADC
    assign i_sel = cfg_q.single_adc_en ? !cfg_q.single_q_adc : cfg_q.pair_order_sel;
    assign lnk.ack_tgl = ack_q;

    always_ff @(posedge link_clk_i) begin
        if (r2_q) begin
            ph_q <= 1'b0;
            second_q <= 1'b0;
            ack_q <= 1'b0;
            data_q <= '0;
            hold_q <= '0;
            flag_q <= 1'b0;
        end else begin
            ph_q <= ~ph_q;
            if (slot_end && second_q) begin
                data_q <= hold_q;
                flag_q <= ~flag_q;
                second_q <= 1'b0;
            end else if (slot_end && fresh) begin
                ack_q <= q2_q;
                data_q <= i_sel ? lnk.word_i : lnk.word_q;
                hold_q <= i_sel ? lnk.word_q : lnk.word_i;
                flag_q <= i_sel ? cfg_q.flag_polarity_sel : !cfg_q.flag_polarity_sel;
                second_q <= !cfg_q.single_adc_en;
            end
        end
    end

    // Port clock edge launches each new word together with its flag
    always_ff @(posedge link_clk_i) begin
        if (r2_q) begin
            clk_q <= 1'b0;
        end else if (cfg_q.ddr_mode) begin
            clk_q <= slot_end ? ~clk_q : clk_q;
        end else begin
            clk_q <= slot_end ^ cfg_q.out_clock_invert;
        end
    end

    assign bus_o = data_q;
    assign port_clk_o = clk_q;
    assign flag_o = flag_q;

    a_ddr_clock_toggle: assert property (@(posedge link_clk_i) disable iff (r2_q)
        (cfg_q.ddr_mode && $stable(cfg_q) && slot_end) |=> (clk_q != $past(clk_q)))
        else $error("ddr clock did not toggle at slot end");
    a_rise_launch: assert property (@(posedge link_clk_i) disable iff (r2_q)
        (!cfg_q.ddr_mode && !cfg_q.out_clock_invert && $changed(data_q)) |-> clk_q)
        else $error("word not launched on rising port clock");
    a_fall_launch: assert property (@(posedge link_clk_i) disable iff (r2_q)
        (!cfg_q.ddr_mode && cfg_q.out_clock_invert && $changed(data_q)) |-> !clk_q)
        else $error("word not launched on falling port clock");
    a_pair_flag_flip: assert property (@(posedge link_clk_i) disable iff (r2_q)
        (slot_end && second_q) |=> (flag_q != $past(flag_q)))
        else $error("second word of pair kept the same flag");
    a_single_flag: assert property (@(posedge link_clk_i) disable iff (r2_q)
        (slot_end && !second_q && fresh && cfg_q.single_adc_en && $stable(cfg_q))
        |=> flag_q == (cfg_q.single_q_adc ^ cfg_q.flag_polarity_sel) && !second_q)
        else $error("single ADC flag does not name active ADC");
endmodule
`default_nettype wire

/* rx_iq_sample_output_port.sv */
// Receive I/Q sample output port: register slave, pair capture, link serializer
//
// Implementation choice: the Wishbone slave port.
`default_nettype none
module rx_iq_sample_output_port
    import rx_port_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire logic [IDX_W+1:0] adr_i,
    input wire logic [WB_DW-1:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [WB_DW-1:0] dat_o,
    output logic ack_o,
    input wire logic [WIDTH-1:0] adc_i_sample_i,
    input wire logic [WIDTH-1:0] adc_q_sample_i,
    input wire logic sample_valid_i,
    output logic sample_ready_o,
    output logic [WIDTH-1:0] shared_sample_bus_o,
    output logic shared_port_clock_o,
    output logic channel_id_flag_o,
    output logic shared_bus_oe_o,
    output logic tx_port_en_o,
    output logic rx_doubler_en_o,
    output logic rx_doubler_sel_o,
    output logic [RX_PW_W-1:0] rx_doubler_pw_o,
    output logic [23:0] dbl_op_point_o,
    output logic [7:0] drive_strength_o
);

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    function automatic logic [3:0] reg_slot(input logic [IDX_W-1:0] idx);
        logic [3:0] s;
        s = SLOT_NONE;
        case (idx)
            DBL_SEL_IDX: s = SLOT_DBL_SEL;
            DBL_OP_A_IDX: s = SLOT_OP_A;
            DBL_OP_B_IDX: s = SLOT_OP_B;
            DBL_OP_C_IDX: s = SLOT_OP_C;
            DBL_PW_IDX: s = SLOT_PW;
            DRIVE_IDX: s = SLOT_DRIVE;
            PORT_CTRL_IDX: s = SLOT_CTRL;
            PORT_STAT_IDX: s = SLOT_STAT;
            default: s = SLOT_NONE;
        endcase
        return s;
    endfunction

    logic [7:0] reg8_q [REG8_N];
    logic [CTRL_W-1:0] ctrl_q;
    port_cfg_t cfg;
    logic ack_q;
    logic [WB_DW-1:0] dat_q;
    logic [3:0] acc_slot;
    logic req_hit;
    logic wr_now;
    logic [WB_DW-1:0] stat_word;
    logic dbl_active;

    assign acc_slot = reg_slot(adr_i[IDX_W+1:2]);
    assign req_hit = cyc_i && stb_i;
    // Write lands on the edge at which the master sees ack
    assign wr_now = req_hit && ack_q && we_i;
    assign cfg = port_cfg_t'(ctrl_q);

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req_hit && !ack_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= '0;
        end else if (req_hit && !ack_q) begin
            if (acc_slot < SLOT_CTRL) begin
                dat_q <= {24'h000000, reg8_q[acc_slot[2:0]]};
            end else if (acc_slot == SLOT_CTRL) begin
                dat_q <= {22'h0, ctrl_q};
            end else if (acc_slot == SLOT_STAT) begin
                dat_q <= stat_word;
            end else begin
                dat_q <= '0;
            end
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

    ////////////////////////////////////////////////////////////////////////
    // Byte-wide registers and the 10-bit port control register

    generate
        for (genvar g = 0; g < REG8_N; g++) begin : g_reg8
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    reg8_q[g] <= REG8_RST;
                end else if (wr_now && sel_i[0] && acc_slot == 4'(g)) begin
                    reg8_q[g] <= dat_i[7:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_now && acc_slot == SLOT_CTRL) begin
            if (sel_i[0]) begin
                ctrl_q[7:0] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
                ctrl_q[CTRL_W-1:8] <= dat_i[CTRL_W-1:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Doubler and port-mode controls

    // Doubler only with bus-rate clock and no decimation
    assign dbl_active = reg8_q[SLOT_DBL_SEL[2:0]][RX_DBL_SEL_BIT]
        && !cfg.ddr_mode && !cfg.decim_en;
    assign rx_doubler_en_o = dbl_active;
    assign rx_doubler_sel_o = reg8_q[SLOT_DBL_SEL[2:0]][RX_DBL_SEL_BIT];
    assign rx_doubler_pw_o = reg8_q[SLOT_PW[2:0]][RX_PW_LSB +: RX_PW_W];
    assign dbl_op_point_o = {reg8_q[SLOT_OP_C[2:0]], reg8_q[SLOT_OP_B[2:0]],
        reg8_q[SLOT_OP_A[2:0]]};
    assign drive_strength_o = reg8_q[SLOT_DRIVE[2:0]];

    // Shared port only sources receive words; transmit pins idle in half duplex
    assign shared_bus_oe_o = cfg.port_en;
    assign tx_port_en_o = !cfg.half_duplex;

    ////////////////////////////////////////////////////////////////////////
    // Pair capture and crossing into the link domain

    pair_link_if lnk ();

    logic [WIDTH-1:0] pair_i_q;
    logic [WIDTH-1:0] pair_q_q;
    logic req_q;
    logic ack1_q;
    logic ack2_q;
    logic take;

    always_ff @(posedge clk_i) begin
        ack1_q <= lnk.ack_tgl;
        ack2_q <= ack1_q;
    end

    // Ready only once the link side has taken the previous pair
    assign sample_ready_o = (req_q == ack2_q) && cfg.port_en;
    assign take = sample_valid_i && sample_ready_o;

    function automatic logic [WIDTH-1:0] fmt(input logic [WIDTH-1:0] s, input logic bin);
        return bin ? {~s[WIDTH-1], s[WIDTH-2:0]} : s;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pair_i_q <= '0;
            pair_q_q <= '0;
            req_q <= 1'b0;
        end else if (take) begin
            // Both channels are taken together as one pair
            pair_i_q <= fmt(adc_i_sample_i, cfg.receive_format_sel);
            pair_q_q <= fmt(adc_q_sample_i, cfg.receive_format_sel);
            req_q <= ~req_q;
        end
    end

    assign lnk.word_i = pair_i_q;
    assign lnk.word_q = pair_q_q;
    assign lnk.req_tgl = req_q;
    assign lnk.cfg = cfg;

    assign stat_word = {29'h0, tx_port_en_o, dbl_active, !(req_q == ack2_q)};

    link_serializer u_link (
        .link_clk_i(link_clk_i),
        .rst_i(rst_i),
        .lnk(lnk.dst),
        .bus_o(shared_sample_bus_o),
        .port_clk_o(shared_port_clock_o),
        .flag_o(channel_id_flag_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_q |=> !ack_q)
        else $error("ack held longer than one cycle");

    a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
        (req_hit && !ack_q) |=> ack_q)
        else $error("ack missing one cycle after request");

    a_format_binary: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && cfg.receive_format_sel) |=>
        pair_i_q == {~$past(adc_i_sample_i[WIDTH-1]), $past(adc_i_sample_i[WIDTH-2:0])})
        else $error("binary format msb not flipped");

    a_format_twos: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && !cfg.receive_format_sel) |=> pair_q_q == $past(adc_q_sample_i))
        else $error("twos complement sample altered");

    a_pair_held: assert property (@(posedge clk_i) disable iff (rst_i)
        take |=> !sample_ready_o ##1 !sample_ready_o)
        else $error("new pair accepted before crossing finished");

    a_doubler_ddr_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (cfg.ddr_mode || cfg.decim_en) |-> !rx_doubler_en_o)
        else $error("doubler active outside plain bus-rate mode");

    a_half_duplex_tx: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_now && acc_slot == SLOT_CTRL && sel_i[0] && dat_i[1]) |=> !tx_port_en_o)
        else $error("transmit port stays on in half duplex");

    a_status_pending: assert property (@(posedge clk_i) disable iff (rst_i)
        take |=> stat_word[STAT_PENDING_BIT])
        else $error("status does not show pending pair");

endmodule
`default_nettype wire

/* iq_sink_model.sv */
// Baseband receiver model capturing words from the shared sample port
`default_nettype none
module iq_sink_model (
    input wire logic link_clk_i,
    input wire logic rst_i,
    input wire logic invert_i,
    input wire logic ddr_i,
    input wire logic [11:0] bus_i,
    input wire logic port_clk_i,
    input wire logic flag_i
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [12:0] words[$];
    logic prev_clk_q;
    logic [12:0] last_q;
    logic launch;

    ////////////////////////////////////////////////////////////////////////
    // Launch edge: any toggle in DDR, else rise, or fall when inverted
    always_comb begin
        if (ddr_i) begin
            launch = prev_clk_q != port_clk_i;
        end else if (invert_i) begin
            launch = prev_clk_q & ~port_clk_i;
        end else begin
            launch = ~prev_clk_q & port_clk_i;
        end
    end

    // Idle clock repeats the held word, so only fresh words are kept
    always @(posedge link_clk_i) begin
        prev_clk_q <= port_clk_i;
        if (rst_i) begin
            last_q <= 13'h0000;
        end else if (launch && {flag_i, bus_i} !== last_q) begin
            words.push_back({flag_i, bus_i});
            last_q <= {flag_i, bus_i};
        end
    end
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the receive sample output port
`default_nettype none
`define check_eq(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rx_port_pkg::*;

    logic clk_i = 0, rst_i = 1, link_clk_i = 0;
    logic [IDX_W+1:0] adr = '0;
    logic [WB_DW-1:0] dat = '0, dat_o, rd;
    logic [3:0] sel = 4'h0;
    logic we = 0, cyc = 0, stb = 0, ack_o, s_valid = 0, sample_ready_o;
    logic [DATA_W-1:0] s_i = '0, s_q = '0, bus;
    logic port_clk, flag, bus_oe, tx_en, dbl_en, dbl_sel, m_inv = 0, m_ddr = 0;
    logic [RX_PW_W-1:0] dbl_pw;
    logic [23:0] op_point;
    logic [7:0] drive;
    logic [9:0] cfgs[9] = '{10'h001, 10'h009, 10'h019, 10'h039, 10'h005, 10'h049,
                           10'h089, 10'h189, 10'h1C9};
    logic [2:0] pws[5] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3};
    logic [12:0] exp_q[$];
    int mismatches = 0, tests_run = 0, cycles = 0;

    rx_iq_sample_output_port dut (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
        .adr_i(adr), .dat_i(dat), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb),
        .dat_o(dat_o), .ack_o(ack_o), .adc_i_sample_i(s_i), .adc_q_sample_i(s_q),
        .sample_valid_i(s_valid), .sample_ready_o(sample_ready_o),
        .shared_sample_bus_o(bus), .shared_port_clock_o(port_clk),
        .channel_id_flag_o(flag), .shared_bus_oe_o(bus_oe), .tx_port_en_o(tx_en),
        .rx_doubler_en_o(dbl_en), .rx_doubler_sel_o(dbl_sel), .rx_doubler_pw_o(dbl_pw),
        .dbl_op_point_o(op_point), .drive_strength_o(drive));

    iq_sink_model sink (.link_clk_i(link_clk_i), .rst_i(rst_i), .invert_i(m_inv),
        .ddr_i(m_ddr), .bus_i(bus), .port_clk_i(port_clk), .flag_i(flag));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        #3.7;
        forever #7.5 link_clk_i = ~link_clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= wr;
        adr <= {idx, 2'b00};
        dat <= wd;
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        rd = dat_o;
        cyc <= 0;
        stb <= 0;
        we <= 0;
        // Let a landed write reach the register outputs before callers look
        @(posedge clk_i);
        if (n >= 50) mismatches++;
    endtask

    task automatic set_cfg(input logic [9:0] c);
        wb(PORT_CTRL_IDX, 1, {22'h0, c});
        m_inv <= c[2];
        m_ddr <= c[6];
        repeat (30) @(posedge clk_i);
    endtask

    function automatic logic [12:0] exp_word(logic [9:0] c, logic is_q, logic [11:0] v);
        return {is_q ? ~c[4] : c[4], c[5] ? {~v[11], v[10:0]} : v};
    endfunction

    // Offer one pair, hold it until taken, then scramble the released lines
    task automatic send_pair(input logic [9:0] c, input logic [11:0] iv, qv);
        int n;
        n = 0;
        if (c[7]) begin
            exp_q.push_back(exp_word(c, c[8], c[8] ? qv : iv));
        end else begin
            exp_q.push_back(exp_word(c, !c[3], c[3] ? iv : qv));
            exp_q.push_back(exp_word(c, c[3], c[3] ? qv : iv));
        end
        @(posedge clk_i);
        s_valid <= 1;
        s_i <= iv;
        s_q <= qv;
        do begin
            @(posedge clk_i);
            n++;
        end while (sample_ready_o !== 1'b1 && n < 500);
        s_valid <= 0;
        s_i <= ~iv;
        s_q <= ~qv;
        #1 `check_eq(sample_ready_o, 1'b0)
        if (n >= 500) mismatches++;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        repeat (10) @(posedge clk_i);
        wb(PORT_CTRL_IDX, 0, 0);
        `check_eq(rd, 32'h00000001)
        wb(PORT_STAT_IDX, 0, 0);
        `check_eq(rd, 32'h00000004)
        `check_eq({tx_en, bus_oe}, 2'b11)
        foreach (pws[k]) begin
            wb(DBL_PW_IDX, 1, {29'h0, pws[k]});
            `check_eq(dbl_pw, pws[k])
        end
        wb(DBL_OP_A_IDX, 0, 0);
        `check_eq(rd, 32'h00000000)
        wb(DBL_OP_A_IDX, 1, 32'h55);
        wb(DBL_OP_B_IDX, 1, 32'h55);
        wb(DBL_OP_C_IDX, 1, 32'h00);
        wb(DRIVE_IDX, 1, 32'hAA);
        `check_eq({op_point, drive}, 32'h005555AA)
        wb(DBL_OP_B_IDX, 0, 0);
        `check_eq(rd, 32'h00000055)
        wb(8'h10, 1, 32'hFF);
        wb(8'h10, 0, 0);
        `check_eq(rd, 32'h00000000)
        wb(PORT_STAT_IDX, 1, 32'hFF);
        wb(DBL_SEL_IDX, 1, 32'h02);
        `check_eq({dbl_sel, dbl_en}, 2'b11)
        wb(PORT_STAT_IDX, 0, 0);
        `check_eq(rd, 32'h00000006)
        set_cfg(10'h041);
        `check_eq(dbl_en, 1'b0)
        set_cfg(10'h201);
        `check_eq(dbl_en, 1'b0)
        set_cfg(10'h003);
        `check_eq({tx_en, bus_oe}, 2'b01)
        foreach (cfgs[k]) begin
            set_cfg(cfgs[k]);
            sink.words.delete();
            exp_q.delete();
            send_pair(cfgs[k], 12'h801 + 12'(k), 12'h3F0 - 12'(k));
            send_pair(cfgs[k], 12'h7FE - 12'(k), 12'h00C + 12'(k));
            repeat (150) @(posedge clk_i);
            `check_eq(sink.words.size(), exp_q.size())
            foreach (exp_q[j]) begin
                `check_eq(sink.words[j], exp_q[j])
            end
        end
        complete_run();
    end
endmodule
`default_nettype wire
